// file: src/rqtr_regs.svh
// register offsets, field positions, reset values and fixed figures of the report bank
// assumes inclusion by bare name from the package and the report module
`ifndef RQTR_REGS_SVH
`define RQTR_REGS_SVH

// register-file identifiers, byte address is four times the index
`define RQTR_IDX_QUALITY   8'h12
`define RQTR_IDX_INTERVAL  8'h13
`define RQTR_IDX_OFFSET    8'h14
`define RQTR_IDX_CONTROL   8'h18
`define RQTR_IDX_STATUS    8'h19

// byte addresses on the register bus
`define RQTR_ADDR_QUALITY  {`RQTR_IDX_QUALITY, 2'b00}
`define RQTR_ADDR_INTERVAL {`RQTR_IDX_INTERVAL, 2'b00}
`define RQTR_ADDR_OFFSET   {`RQTR_IDX_OFFSET, 2'b00}
`define RQTR_ADDR_CONTROL  {`RQTR_IDX_CONTROL, 2'b00}
`define RQTR_ADDR_STATUS   {`RQTR_IDX_STATUS, 2'b00}
`define RQTR_ADDR_W        10

// quality word field positions
`define RQTR_AMP_LSB       0
`define RQTR_AMP_MSB       15
`define RQTR_PWR_LSB       16
`define RQTR_PWR_MSB       31
`define RQTR_FIELD_W       16

// tracking figures
`define RQTR_INTERVAL_16M  32'h01F00000
`define RQTR_INTERVAL_64M  32'h01FC0000
`define RQTR_OFFSET_W      19

// control and status bits
`define RQTR_CTL_PRF64     0
`define RQTR_STS_QVALID    0
`define RQTR_STS_IVALID    1
`define RQTR_STS_CNT_LSB   16
`define RQTR_CNT_W         16

// reset values
`define RQTR_RESET_WORD    32'h00000000

`endif

// file: src/rqtr_pkg.sv
// types shared by the report bank modules
// assumes the register header sits beside it
`include "rqtr_regs.svh"

package rqtr_pkg;

  // frame-quality word as it sits in the register
  typedef struct packed {
    logic [`RQTR_FIELD_W-1:0] power;    // bits 31..16
    logic [`RQTR_FIELD_W-1:0] ampOnePast; // bits 15..0
  } rqtr_quality_type;

  // register bus answer state, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } rqtr_bus_state_type;

endpackage : rqtr_pkg

// file: src/rqtr_hold_reg.sv
// one report register that captures its input on a load pulse
// assumes load comes from logic on the same clock
`timescale 1ns/10ps
`default_nettype none

module rqtr_hold_reg
  import rqtr_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // capture
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] dataIn,
  // held value
  output var  logic [WIDTH-1:0] dataOut
);

  // refuse a width the register cannot hold, at elaboration
  if (WIDTH < 1)
  begin : gWidthCheck
    $error("rqtr_hold_reg: WIDTH must be at least 1");
  end

  // zero at reset, new value only on load
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dataOut <= '0;
    end
    else if (load)
    begin
      dataOut <= dataIn;
    end
  end

endmodule : rqtr_hold_reg

`default_nettype wire

// file: src/rqtr_report.sv
// receive quality and time-tracking report bank with an avalon-mm slave
// assumes edge and demodulation events are one-cycle pulses on clk_sys
//
// Overview of operation
// - low quality field: tap one past first path
// - high quality field: channel response power sum
// - tracking interval at index 0x13, read-only
// - interval changes only on demodulation done
// - interval 0x01F00000 at 16M, 0x01FC0000 at 64M
// - quality fields update on edge-detect done
// - quality register at index 0x12, read-only
// - tracking offset is 19-bit signed quantity
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rqtr_regs.svh"

module rqtr_report
  import rqtr_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // avalon-mm slave
  input  wire logic [`RQTR_ADDR_W-1:0]  address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [3:0]               byteenable,
  input  wire logic [31:0]              writedata,
  output var  logic [31:0]              readdata,
  output logic                          waitrequest,
  // leading edge detector results
  input  wire logic                     edgeDetectDone,
  input  wire logic [`RQTR_FIELD_W-1:0] firstPathAmpTapOnePast,
  input  wire logic [`RQTR_FIELD_W-1:0] channelResponsePower,
  // demodulator results
  input  wire logic                     demodDone,
  input  wire logic [`RQTR_OFFSET_W-1:0] trackingOffsetValue
);

  rqtr_bus_state_type       busState;        // bus answer state
  rqtr_bus_state_type       next_busState;   // next bus state
  rqtr_quality_type         rxQualityWord;   // held quality word
  rqtr_quality_type         newQuality;      // quality word to capture
  logic [31:0]              rxTrackingInterval; // held interval
  logic [31:0]              newInterval;     // interval for this prf
  logic [`RQTR_OFFSET_W-1:0] rxTrackingOffset; // held signed offset
  logic                     prf64;           // control: 64 MHz prf selected
  logic                     qualityValid;    // a quality word was captured
  logic                     intervalValid;   // an interval was captured
  logic [`RQTR_CNT_W-1:0]   frameCount;      // successful demodulations
  logic [31:0]              next_readdata;   // read mux
  logic                     accept;          // request taken this edge

  // quality fields in place
  assign newQuality.ampOnePast = firstPathAmpTapOnePast;
  assign newQuality.power      = channelResponsePower;

  // interval depends only on the prf setting
  assign newInterval = prf64 ? `RQTR_INTERVAL_64M : `RQTR_INTERVAL_16M;

  // quality word, captured on edge-detect done
  rqtr_hold_reg #(
    .WIDTH   ($bits(rqtr_quality_type))
  ) uQuality (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (edgeDetectDone),
    .dataIn  (newQuality),
    .dataOut (rxQualityWord)
  );

  // interval, captured on demodulation done
  rqtr_hold_reg #(
    .WIDTH   (32)
  ) uInterval (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (demodDone),
    .dataIn  (newInterval),
    .dataOut (rxTrackingInterval)
  );

  // signed offset, captured with the interval it pairs with
  rqtr_hold_reg #(
    .WIDTH   (`RQTR_OFFSET_W)
  ) uOffset (
    .clk_sys (clk_sys),
    .rst     (rst),
    .load    (demodDone),
    .dataIn  (trackingOffsetValue),
    .dataOut (rxTrackingOffset)
  );

  // bus answers one cycle after the request appears
  always_comb
  begin
    next_busState = BUS_IDLE;
    case (busState)
      BUS_IDLE:
      begin
        // new request: answer next cycle
        if (read || write)
        begin
          next_busState = BUS_ANSWER;
        end
      end
      BUS_ANSWER:
      begin
        // request taken, back to idle
        next_busState = BUS_IDLE;
      end
      default:
      begin
        next_busState = BUS_IDLE;
      end
    endcase
  end

  // bus state register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busState <= BUS_IDLE;
    end
    else
    begin
      busState <= next_busState;
    end
  end

  // waitrequest drops in the answer cycle
  assign waitrequest = (read || write) && (busState != BUS_ANSWER);
  assign accept      = (read || write) && (busState == BUS_ANSWER);

  // read mux, unmapped and unaligned addresses read zero
  always_comb
  begin
    next_readdata = `RQTR_RESET_WORD;
    case (address)
      `RQTR_ADDR_QUALITY:
      begin
        next_readdata = rxQualityWord;
      end
      `RQTR_ADDR_INTERVAL:
      begin
        next_readdata = rxTrackingInterval;
      end
      `RQTR_ADDR_OFFSET:
      begin
        next_readdata = {{(32-`RQTR_OFFSET_W){1'b0}}, rxTrackingOffset};
      end
      `RQTR_ADDR_CONTROL:
      begin
        next_readdata[`RQTR_CTL_PRF64] = prf64;
      end
      `RQTR_ADDR_STATUS:
      begin
        next_readdata[`RQTR_STS_QVALID] = qualityValid;
        next_readdata[`RQTR_STS_IVALID] = intervalValid;
        next_readdata[`RQTR_STS_CNT_LSB +: `RQTR_CNT_W] = frameCount;
      end
      default:
      begin
        next_readdata = `RQTR_RESET_WORD;
      end
    endcase
  end

  // read data registered while the request waits
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      readdata <= `RQTR_RESET_WORD;
    end
    else if (read && (busState == BUS_IDLE))
    begin
      readdata <= next_readdata;
    end
  end

  // control register, the only writable one
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prf64 <= 1'b0;
    end
    else if (accept && write && (address == `RQTR_ADDR_CONTROL) && byteenable[0])
    begin
      prf64 <= writedata[`RQTR_CTL_PRF64];
    end
  end

  // valid flags and frame counter, set by events only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      qualityValid  <= 1'b0;
      intervalValid <= 1'b0;
      frameCount    <= '0;
    end
    else
    begin
      if (edgeDetectDone)
      begin
        qualityValid <= 1'b1;
      end
      if (demodDone)
      begin
        intervalValid <= 1'b1;
        frameCount    <= frameCount + 1'b1;
      end
    end
  end

  // checks on the report bank
  a_amp_field: assert property (@(posedge clk_sys) disable iff (rst)
    edgeDetectDone |=> rxQualityWord[`RQTR_AMP_MSB:`RQTR_AMP_LSB] ==
      $past(firstPathAmpTapOnePast))
    else $error("amplitude field not captured");

  a_power_field: assert property (@(posedge clk_sys) disable iff (rst)
    edgeDetectDone |=> rxQualityWord[`RQTR_PWR_MSB:`RQTR_PWR_LSB] ==
      $past(channelResponsePower))
    else $error("power field not captured");

  a_interval_read: assert property (@(posedge clk_sys) disable iff (rst)
    (read && busState == BUS_IDLE && address == `RQTR_ADDR_INTERVAL)
      |=> !waitrequest && readdata == $past(rxTrackingInterval))
    else $error("interval read wrong");

  a_interval_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !demodDone |=> $stable(rxTrackingInterval))
    else $error("interval changed without demodulation");

  a_interval_value: assert property (@(posedge clk_sys) disable iff (rst)
    demodDone |=> rxTrackingInterval ==
      ($past(prf64) ? `RQTR_INTERVAL_64M : `RQTR_INTERVAL_16M))
    else $error("interval value wrong for prf");

  a_quality_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !edgeDetectDone |=> $stable(rxQualityWord))
    else $error("quality changed without edge detection");

  a_quality_read: assert property (@(posedge clk_sys) disable iff (rst)
    (read && busState == BUS_IDLE && address == `RQTR_ADDR_QUALITY)
      |=> readdata == $past(rxQualityWord))
    else $error("quality read wrong");

  a_offset_width: assert property (@(posedge clk_sys) disable iff (rst)
    (read && busState == BUS_IDLE && address == `RQTR_ADDR_OFFSET)
      |=> readdata[31:`RQTR_OFFSET_W] == '0 &&
          readdata[`RQTR_OFFSET_W-1:0] == $past(rxTrackingOffset))
    else $error("offset read wrong");

  a_zero_before: assert property (@(posedge clk_sys) disable iff (rst)
    !qualityValid |-> rxQualityWord == `RQTR_RESET_WORD)
    else $error("quality nonzero before first frame");

  a_write_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    (write && !demodDone && address == `RQTR_ADDR_INTERVAL) |=> $stable(rxTrackingInterval))
    else $error("write altered interval");

  a_wait_bound: assert property (@(posedge clk_sys) disable iff (rst)
    (read || write) |-> ##[0:1] !waitrequest)
    else $error("bus answer too late");

  // main scenarios
  c_quality_update: cover property (@(posedge clk_sys) disable iff (rst) edgeDetectDone);
  c_interval_read: cover property (@(posedge clk_sys) disable iff (rst)
    accept && read && address == `RQTR_ADDR_INTERVAL);
  c_control_write: cover property (@(posedge clk_sys) disable iff (rst)
    accept && write && address == `RQTR_ADDR_CONTROL);
  c_prf64_frame: cover property (@(posedge clk_sys) disable iff (rst) demodDone && prf64);

endmodule : rqtr_report

`default_nettype wire

// file: verif/rqtr_host.sv
// host model: avalon-mm master that reads and writes the report bank
// assumes it shares clk_sys with the bank and is called right after an edge
`timescale 1ns/10ps
`default_nettype none

module rqtr_host
(
  // clock
  input  wire logic        clk_sys,
  // avalon-mm master side
  output var  logic [9:0]  address,
  output var  logic        read,
  output var  logic        write,
  output var  logic [3:0]  byteenable,
  output var  logic [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  // idle bus at time zero
  initial
  begin
    address <= 10'h000;
    read <= 1'b0;
    write <= 1'b0;
    byteenable <= 4'h0;
    writedata <= 32'h00000000;
  end

  // wait for the rising edge at which waitrequest is sampled low
  // only the bench watchdog ends a wait that never comes
  task automatic waitAnswer();
    @(posedge clk_sys);
    while (waitrequest !== 1'b0)
    begin
      @(posedge clk_sys);
    end
  endtask : waitAnswer

  // one read, request held until the taking edge
  task automatic busRead(input logic [9:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    read <= 1'b1;
    waitAnswer();
    d = readdata;
    read <= 1'b0;
  endtask : busRead

  // one write, data scrambled once released
  task automatic busWrite(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    write <= 1'b1;
    waitAnswer();
    write <= 1'b0;
    writedata <= ~d;
  endtask : busWrite

  // clock offset as offset over interval
  function automatic real offsetRatio(logic [18:0] ofs, logic [31:0] ivl);
    return $itor($signed(ofs)) / $itor(ivl);
  endfunction : offsetRatio
endmodule : rqtr_host

`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench of the report bank
// assumes the register header and package are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "rqtr_regs.svh"

module tb_top
  import rqtr_pkg::*;
;
  logic        clk_sys;        // 20 MHz system clock
  logic        rst;            // async reset
  logic [9:0]  address;        // bus address
  logic        read;           // bus read
  logic        write;          // bus write
  logic [3:0]  byteenable;     // bus lanes
  logic [31:0] writedata;      // bus write data
  logic [31:0] readdata;       // bus read data
  logic        waitrequest;    // bus stall
  logic        edgeDetectDone; // edge detect pulse
  logic [15:0] ampTap;         // amp tap one past
  logic [15:0] cirPower;       // response power
  logic        demodDone;      // demod pulse
  logic [18:0] trkOffset;      // tracking offset
  int          errTotal;       // mismatches
  int          samplesChecked; // comparisons
  logic [31:0] ivlSeen;        // interval read back
  logic [31:0] ofsSeen;        // offset read back

  rqtr_report dut_u (.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .edgeDetectDone(edgeDetectDone),
    .firstPathAmpTapOnePast(ampTap), .channelResponsePower(cirPower),
    .demodDone(demodDone), .trackingOffsetValue(trkOffset));

  rqtr_host host_u (.clk_sys(clk_sys), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));

  // clock generator
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic checkVal(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : checkVal

  // read a register and compare
  task automatic rd(input string name, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host_u.busRead(a, v);
    checkVal(name, v, exp);
  endtask : rd

  // one-cycle event pulses with their data
  task automatic pulseEdge(input logic [15:0] amp, input logic [15:0] pwr);
    @(posedge clk_sys);
    edgeDetectDone <= 1'b1;
    ampTap <= amp;
    cirPower <= pwr;
    @(posedge clk_sys);
    edgeDetectDone <= 1'b0;
    ampTap <= ~amp;
    cirPower <= ~pwr;
  endtask : pulseEdge

  task automatic pulseDemod(input logic [18:0] ofs);
    @(posedge clk_sys);
    demodDone <= 1'b1;
    trkOffset <= ofs;
    @(posedge clk_sys);
    demodDone <= 1'b0;
    trkOffset <= ~ofs;
  endtask : pulseDemod

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // watchdog, far beyond the roughly 80 cycles of the tests
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    errTotal++;
    test_done();
  end

  // main sequence
  initial
  begin
    errTotal = 0;
    samplesChecked = 0;
    rst <= 1'b1;
    edgeDetectDone <= 1'b0;
    demodDone <= 1'b0;
    ampTap <= 16'h0000;
    cirPower <= 16'h0000;
    trkOffset <= 19'h00000;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd("quality", `RQTR_ADDR_QUALITY, 32'h00000000);
    rd("interval", `RQTR_ADDR_INTERVAL, 32'h00000000);
    $display("test reset values done");
    pulseEdge(16'h1234, 16'hABCD);
    rd("quality", `RQTR_ADDR_QUALITY, 32'hABCD1234);
    rd("interval", `RQTR_ADDR_INTERVAL, 32'h00000000);
    $display("test quality capture done");
    pulseDemod(19'h7FF5C);
    rd("interval", `RQTR_ADDR_INTERVAL, 32'h01F00000);
    rd("offset", `RQTR_ADDR_OFFSET, 32'h0007FF5C);
    rd("quality", `RQTR_ADDR_QUALITY, 32'hABCD1234);
    host_u.busRead(`RQTR_ADDR_OFFSET, ofsSeen);
    host_u.busRead(`RQTR_ADDR_INTERVAL, ivlSeen);
    checkVal("ppm", 32'($rtoi(host_u.offsetRatio(ofsSeen[18:0], ivlSeen) * 1.0e6)), 32'hFFFFFFFB);
    host_u.busWrite(`RQTR_ADDR_CONTROL, 32'h00000001);
    pulseDemod(19'h000E4);
    rd("interval", `RQTR_ADDR_INTERVAL, 32'h01FC0000);
    $display("test tracking interval done");
    host_u.busWrite(`RQTR_ADDR_INTERVAL, 32'h5A5A5A5A);
    host_u.busWrite(`RQTR_ADDR_QUALITY, 32'h00000000);
    rd("interval", `RQTR_ADDR_INTERVAL, 32'h01FC0000);
    rd("quality", `RQTR_ADDR_QUALITY, 32'hABCD1234);
    rd("unmapped", 10'h3FC, 32'h00000000);
    rd("control", `RQTR_ADDR_CONTROL, 32'h00000001);
    rd("status", `RQTR_ADDR_STATUS, 32'h00020003);
    $display("test write protection done");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd("quality", `RQTR_ADDR_QUALITY, 32'h00000000);
    rd("interval", `RQTR_ADDR_INTERVAL, 32'h00000000);
    rd("status", `RQTR_ADDR_STATUS, 32'h00000000);
    rd("control", `RQTR_ADDR_CONTROL, 32'h00000000);
    $display("test mid-run reset done");
    test_done();
  end
endmodule : tb_top

`default_nettype wire
